//--- dv/rar_link_sva.sv
`timescale 1ns/100ps
`default_nettype none
// ==================
// Link checker
// ==================
module rar_link_sva
  import rar_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [ANGLE_W-1:0] angleWord,
  input wire logic busy,
  input wire logic hold_output_ctl_n
);
  logic [7:0] lowCnt_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Strobe low length
  always_ff @(posedge clk_sys) begin
    if (!rstn || hold_output_ctl_n) begin
      lowCnt_q <= 8'h00;
    end else begin
      lowCnt_q <= lowCnt_q + 8'h01;
    end
  end
  word_step_a:
    assert property ($changed(angleWord) |-> ##[0:4] busy) else $error("word moved without busy");
  hold_release_a:
    assert property ($rose(hold_output_ctl_n) |-> ##[1:6] busy) else $error("no busy after release");
  busy_width_a:
    assert property ($rose(busy) |=> busy) else $error("busy too short");
  unit_step_a:
    assert property (hold_output_ctl_n [*6] ##0 $changed(angleWord) |->
      angleWord == $past(angleWord) + 16'h0001 || angleWord == $past(angleWord) - 16'h0001)
      else $error("word jumped");
  frozen_word_a:
    assert property (!hold_output_ctl_n [*5] |-> $stable(angleWord)) else $error("word moved in hold");
  capture_stable_a:
    assert property ($rose(hold_output_ctl_n) |-> $stable(angleWord)) else $error("capture unstable");
  strobe_width_a:
    assert property ($rose(hold_output_ctl_n) |-> lowCnt_q >= READ_STROBE_CYC) else $error("strobe short");
  strobe_max_a:
    assert property (lowCnt_q <= READ_STROBE_CYC) else $error("strobe long");
  // Main scenarios
  cover property ($rose(hold_output_ctl_n));
  cover property ($rose(busy));
  cover property ($changed(angleWord));
endmodule // rar_link_sva
`default_nettype wire

//--- dv/test_resolver_angle_readout.sv
`timescale 1ns/100ps
`default_nettype none
// ==================
// Bench
// ==================
module test_resolver_angle_readout
  import rar_pkg::*;
;
  logic clk_sys = 0, rstn = 0, stepUp = 0, stepDown = 0, readReq = 0, trailEdge = 0, tableWe = 0;
  rar_mode_t readMode = RAR_MODE_IDLE;
  logic [7:0] tableIdx = 8'h00;
  logic [15:0] tableData = 16'h0000, ang = 16'h0000, a0;
  logic readBusy, readDone, readFail;
  logic [15:0] counterAngle, rawAngle, correctedAngle, interpolated_offset;
  int mismatches = 0, compares = 0;
  rar_link_if link();
  rar_converter_end rar_converter_end_i (.clk_sys(clk_sys), .rstn(rstn), .stepUp(stepUp),
    .stepDown(stepDown), .counterAngle(counterAngle), .link(link));
  rar_reader_end rar_reader_end_i (.clk_sys(clk_sys), .rstn(rstn), .readMode(readMode),
    .readReq(readReq), .trailEdge(trailEdge), .tableWe(tableWe), .tableIdx(tableIdx),
    .tableData(tableData), .readBusy(readBusy), .readDone(readDone), .readFail(readFail),
    .rawAngle(rawAngle), .correctedAngle(correctedAngle),
    .interpolated_offset(interpolated_offset), .link(link));
  rar_link_sva rar_link_sva_i (.clk_sys(clk_sys), .rstn(rstn), .angleWord(link.angleWord),
    .busy(link.busy), .hold_output_ctl_n(link.hold_output_ctl_n));
  always #5 clk_sys = ~clk_sys;
  // Compare tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t word %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t flag %b exp %b", $time, got, exp);
    end
  endtask
  // Offset table write
  task automatic wr(input logic [7:0] i, input logic [15:0] d);
    @(posedge clk_sys);
    tableWe <= 1'b1;
    tableIdx <= i;
    tableData <= d;
    @(posedge clk_sys);
    tableWe <= 1'b0;
  endtask
  // Count steps, one per cycle
  task automatic step(input logic up, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      stepUp <= up;
      stepDown <= !up;
      ang = up ? ang + 16'h0001 : ang - 16'h0001;
    end
    @(posedge clk_sys);
    stepUp <= 1'b0;
    stepDown <= 1'b0;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  // Read, with n up-steps after d cycles
  task automatic rd(input rar_mode_t m, input int d, input int n);
    @(posedge clk_sys);
    readMode <= m;
    readReq <= 1'b1;
    @(posedge clk_sys);
    readReq <= 1'b0;
    repeat (d) @(posedge clk_sys);
    repeat (n) begin
      @(posedge clk_sys);
      stepUp <= 1'b1;
      ang = ang + 16'h0001;
    end
    if (n > 0) begin
      @(posedge clk_sys);
      stepUp <= 1'b0;
    end
    @(negedge clk_sys);
    for (int k = 0; k < 800 && readDone !== 1'b1; k++) @(negedge clk_sys);
    chkb(readDone, 1'b1);
  endtask
  // Compare read while the shaft keeps stepping must give up
  task automatic rdFail;
    @(posedge clk_sys);
    readMode <= RAR_MODE_COMPARE;
    readReq <= 1'b1;
    stepUp <= 1'b1;
    @(posedge clk_sys);
    readReq <= 1'b0;
    repeat (COMPARE_GAP_CYC / 2) @(posedge clk_sys);
    @(negedge clk_sys);
    chkb(readBusy, 1'b1);
    chkb(readDone, 1'b0);
    repeat (COMPARE_GAP_CYC / 2 + 8) @(posedge clk_sys);
    stepUp <= 1'b0;
    @(negedge clk_sys);
    chkb(readFail, 1'b1);
    chkb(readBusy, 1'b0);
  endtask
  task automatic results;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #200us;
    mismatches++;
    results;
  end
  // Scenarios
  initial begin
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    wr(8'h00, 16'h0005);
    wr(8'h01, 16'h1005);
    step(1'b1, 5);
    step(1'b0, 2);
    chk(counterAngle, ang);
    chk(link.angleWord, ang);
    repeat (20) begin
      @(negedge clk_sys);
      chkb(link.busy, 1'b0);
    end
    rd(RAR_MODE_IDLE, 0, 0);
    chk(rawAngle, ang);
    rd(RAR_MODE_COMPARE, 0, 0);
    chk(rawAngle, ang);
    chkb(readFail, 1'b0);
    rd(RAR_MODE_STROBE, 0, 0);
    chk(rawAngle, ang);
    // Angle 3: fraction 540/65536 of the 0x1000 rise between entries
    chk(interpolated_offset, 16'h0026);
    chk(correctedAngle, ang + 16'h0026);
    a0 = ang;
    rd(RAR_MODE_STROBE, 20, 3);
    chk(rawAngle, a0);
    repeat (8) @(negedge clk_sys);
    chk(link.angleWord, ang);
    rd(RAR_MODE_BUSY, 0, 1);
    chk(rawAngle, ang);
    @(posedge clk_sys);
    trailEdge <= 1'b1;
    rd(RAR_MODE_BUSY, 0, 1);
    chk(rawAngle, ang);
    step(1'b0, 9);
    chk(counterAngle, 16'hffff);
    rdFail;
    results;
  end
endmodule // test_resolver_angle_readout
`default_nettype wire

//--- rtl/rar_converter_end.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Converter end: counter, busy pulses, frozen output word
// ==========================================================
module rar_converter_end
  import rar_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic stepUp,
  input wire logic stepDown,
  output logic [ANGLE_W-1:0] counterAngle,
  rar_link_if.conv link
);
  logic [ANGLE_W-1:0] count_q;
  logic [ANGLE_W-1:0] word_q;
  logic [1:0] busyCnt_q;
  logic holdMeta_q;
  logic holdSync_q;
  logic holdPrev_q;
  logic step;
  logic stepSeen_q;
  logic holdRise;

  assign step = stepUp ^ stepDown;
  assign holdRise = holdSync_q & ~holdPrev_q;

  // Hold control comes from the other party: sync it
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      holdMeta_q <= 1'b1;
      holdSync_q <= 1'b1;
      holdPrev_q <= 1'b1;
    end else begin
      holdMeta_q <= link.hold_output_ctl_n;
      holdSync_q <= holdMeta_q;
      holdPrev_q <= holdSync_q;
    end
  end

  // Angle counter, one count per step
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      count_q <= ANGLE_RST;
    end else if (stepUp && !stepDown) begin
      count_q <= count_q + 16'h0001;
    end else if (stepDown && !stepUp) begin
      count_q <= count_q - 16'h0001;
    end
  end

  // Presented word frozen while hold is low
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      word_q <= ANGLE_RST;
    end else if (holdSync_q) begin
      word_q <= count_q;
    end
  end

  // Step seen last cycle: busy then lines up with the word update
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      stepSeen_q <= 1'b0;
    end else begin
      stepSeen_q <= step;
    end
  end

  // Busy pulse on each step and after hold release
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      busyCnt_q <= 2'h0;
    end else if (stepSeen_q || holdRise) begin
      busyCnt_q <= 2'(BUSY_CYC);
    end else if (busyCnt_q != 2'h0) begin
      busyCnt_q <= busyCnt_q - 2'h1;
    end
  end

  // No step and no hold release means no busy, word stable
  assign link.busy = (busyCnt_q != 2'h0);
  assign link.angleWord = word_q;
  assign counterAngle = count_q;
endmodule // rar_converter_end
`default_nettype wire

//--- rtl/rar_link_if.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Parallel angle link between converter and reader
// ==========================================================
interface rar_link_if;
  import rar_pkg::*;
  logic [ANGLE_W-1:0] angleWord;
  logic busy;
  logic hold_output_ctl_n;

  modport conv (output angleWord, output busy, input hold_output_ctl_n);
  modport reader (input angleWord, input busy, output hold_output_ctl_n);
endinterface
`default_nettype wire

//--- rtl/rar_pkg.sv
package rar_pkg;
  // ==========================================================
  // Word layout and timing
  // ==========================================================
  localparam int ANGLE_W = 16;
  localparam int OFFSET_W = 16;
  localparam int SYS_CLK_MHZ = 100;
  localparam int CLK_PERIOD_NS = 10;
  // Least strobe width, in ns
  localparam int READ_STROBE_NS = 1200;
  localparam int READ_STROBE_CYC = (READ_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least hold-output low time, in ns
  localparam int HOLD_LOW_NS = 400;
  localparam int HOLD_LOW_CYC = (HOLD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Longest compare read before giving up, in ns
  localparam int COMPARE_GAP_NS = 5000;
  localparam int COMPARE_GAP_CYC = COMPARE_GAP_NS / CLK_PERIOD_NS;
  // Least reader clock, in MHz
  localparam int MIN_READ_CLK_MHZ = 10;
  // Busy pulse length in cycles
  localparam int BUSY_CYC = 2;
  // Correction table: 2 degree steps over 360 degrees
  localparam int TABLE_STEP_DEG = 2;
  localparam int TABLE_SPAN_DEG = 360;
  localparam int TABLE_DEPTH = TABLE_SPAN_DEG / TABLE_STEP_DEG;
  localparam int TABLE_IDX_W = 8;
  localparam logic [ANGLE_W-1:0] ANGLE_RST = 16'h0000;
  localparam logic [OFFSET_W-1:0] OFFSET_RST = 16'h0000;
  localparam logic [7:0] CNT_RST = 8'h00;

  // Reader read modes
  typedef enum logic [1:0] {
    RAR_MODE_BUSY = 2'h0,
    RAR_MODE_COMPARE = 2'h1,
    RAR_MODE_STROBE = 2'h2,
    RAR_MODE_IDLE = 2'h3
  } rar_mode_t;

  // Reader states, one-hot
  typedef enum logic [4:0] {
    RAR_ST_IDLE = 5'h01,
    RAR_ST_FIRST = 5'h02,
    RAR_ST_SECOND = 5'h04,
    RAR_ST_STROBE = 5'h08,
    RAR_ST_CORR = 5'h10
  } rar_state_t;
endpackage

//--- rtl/rar_reader_end.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Reader end
// ==========================================================
module rar_reader_end
  import rar_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire rar_mode_t readMode,
  input wire logic readReq,
  input wire logic trailEdge,
  input wire logic tableWe,
  input wire logic [TABLE_IDX_W-1:0] tableIdx,
  input wire logic [OFFSET_W-1:0] tableData,
  output logic readBusy,
  output logic readDone,
  output logic readFail,
  output logic [ANGLE_W-1:0] rawAngle,
  output logic [ANGLE_W-1:0] correctedAngle,
  output logic [OFFSET_W-1:0] interpolated_offset,
  rar_link_if.reader link
);
  // Reader clock meets the strobe circuit minimum
  localparam int CLK_OK = (SYS_CLK_MHZ >= MIN_READ_CLK_MHZ) ? 1 : 0;

  rar_state_t state_q;
  logic [ANGLE_W-1:0] syncA_q;
  logic [ANGLE_W-1:0] syncB_q;
  logic busyA_q;
  logic busyB_q;
  logic busyPrev_q;
  logic [ANGLE_W-1:0] first_q;
  logic [ANGLE_W-1:0] raw_q;
  logic [ANGLE_W-1:0] corr_q;
  logic [OFFSET_W-1:0] offs_q;
  logic [8:0] cnt_q;
  logic strobeN_q;
  logic done_q;
  logic fail_q;
  logic [OFFSET_W-1:0] table_q [TABLE_DEPTH];
  logic busyEdge;
  logic [TABLE_IDX_W-1:0] lowIdx;
  logic [TABLE_IDX_W-1:0] highIdx;
  logic [ANGLE_W-1:0] frac;
  logic signed [OFFSET_W-1:0] lowerOffset;
  logic signed [OFFSET_W-1:0] upper_entry_offset;
  logic signed [OFFSET_W+ANGLE_W:0] prod;

  // Map angle word to table entry: angle*180 / 2^16
  function automatic logic [TABLE_IDX_W-1:0] entryOf(input logic [ANGLE_W-1:0] a);
    logic [ANGLE_W+TABLE_IDX_W-1:0] scaled;
    scaled = 24'(a) * 24'(TABLE_DEPTH);
    return scaled[ANGLE_W+TABLE_IDX_W-1:ANGLE_W];
  endfunction

  // Fraction between entries, as 16-bit fraction
  function automatic logic [ANGLE_W-1:0] fracOf(input logic [ANGLE_W-1:0] a);
    logic [ANGLE_W+TABLE_IDX_W-1:0] scaled;
    scaled = 24'(a) * 24'(TABLE_DEPTH);
    return scaled[ANGLE_W-1:0];
  endfunction

  // Busy and word arrive from the converter: two flops first
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      busyA_q <= 1'b0;
      busyB_q <= 1'b0;
      busyPrev_q <= 1'b0;
      syncA_q <= ANGLE_RST;
      syncB_q <= ANGLE_RST;
    end else begin
      busyA_q <= link.busy;
      busyB_q <= busyA_q;
      busyPrev_q <= busyB_q;
      syncA_q <= link.angleWord;
      syncB_q <= syncA_q;
    end
  end

  // Chosen edge of busy marks a stable word
  assign busyEdge = trailEdge ? (busyPrev_q & ~busyB_q) : (busyB_q & ~busyPrev_q);

  // Correction table storage
  always_ff @(posedge clk_sys) begin
    if (tableWe && (tableIdx < 8'(TABLE_DEPTH))) begin
      table_q[tableIdx] <= tableData;
    end
  end

  // Interpolation of neighbouring entries
  assign lowIdx = entryOf(raw_q);
  assign highIdx = (lowIdx == 8'(TABLE_DEPTH - 1)) ? 8'h00 : lowIdx + 8'h01;
  assign frac = fracOf(raw_q);
  assign lowerOffset = table_q[lowIdx];
  assign upper_entry_offset = table_q[highIdx];
  assign prod = (33'(signed'(upper_entry_offset)) - 33'(signed'(lowerOffset))) * signed'({1'b0, frac});

  // Read sequencer
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_q <= RAR_ST_IDLE;
      cnt_q <= 9'h000;
      strobeN_q <= 1'b1;
      first_q <= ANGLE_RST;
      raw_q <= ANGLE_RST;
      done_q <= 1'b0;
      fail_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        RAR_ST_IDLE: begin
          cnt_q <= 9'h000;
          if (readReq) begin
            fail_q <= 1'b0;
            unique case (readMode)
              RAR_MODE_IDLE: begin
                raw_q <= syncB_q;
                state_q <= RAR_ST_CORR;
              end
              RAR_MODE_STROBE: begin
                strobeN_q <= 1'b0;
                state_q <= RAR_ST_STROBE;
              end
              RAR_MODE_COMPARE: begin
                first_q <= syncB_q;
                state_q <= RAR_ST_SECOND;
              end
              RAR_MODE_BUSY: state_q <= RAR_ST_FIRST;
            endcase
          end
        end
        RAR_ST_FIRST: begin
          // Sample at the chosen busy edge: inside the busy interval, or just after it with trailEdge
          if (busyEdge) begin
            raw_q <= syncB_q;
            state_q <= RAR_ST_CORR;
          end
        end
        RAR_ST_SECOND: begin
          cnt_q <= cnt_q + 9'h001;
          // Samples paired 4 cycles apart; give up at the gap limit
          if ((cnt_q[1:0] == 2'h3) && (syncB_q[ANGLE_W-1:1] == first_q[ANGLE_W-1:1])) begin
            raw_q <= syncB_q;
            state_q <= RAR_ST_CORR;
          end else if (cnt_q == 9'(COMPARE_GAP_CYC - 1)) begin
            fail_q <= 1'b1;
            state_q <= RAR_ST_IDLE;
          end else if (cnt_q[1:0] == 2'h3) begin
            first_q <= syncB_q;
          end
        end
        RAR_ST_STROBE: begin
          cnt_q <= cnt_q + 9'h001;
          // Strobe low long enough for the hold minimum
          if (cnt_q == 9'(READ_STROBE_CYC - 1)) begin
            strobeN_q <= 1'b1;
            raw_q <= syncB_q;
            state_q <= RAR_ST_CORR;
          end
        end
        RAR_ST_CORR: begin
          done_q <= 1'b1;
          state_q <= RAR_ST_IDLE;
        end
        default: state_q <= RAR_ST_IDLE;
      endcase
    end
  end

  // Corrected angle registered at completion
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      offs_q <= OFFSET_RST;
      corr_q <= ANGLE_RST;
    end else if (state_q == RAR_ST_CORR) begin
      offs_q <= 16'(lowerOffset + 16'(prod >>> ANGLE_W));
      corr_q <= raw_q + 16'(lowerOffset + 16'(prod >>> ANGLE_W));
    end
  end

  assign link.hold_output_ctl_n = strobeN_q;
  assign readBusy = (state_q != RAR_ST_IDLE) || (CLK_OK == 0);
  assign readDone = done_q;
  assign readFail = fail_q;
  assign rawAngle = raw_q;
  assign correctedAngle = corr_q;
  assign interpolated_offset = offs_q;
endmodule // rar_reader_end
`default_nettype wire
